// [fes_pkg.sv]
// Constants, register map and carrier types for the flash failure/status block.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
//
// Behaviour
// - Program that cannot turn targeted ones to zeros sets program failure.
// - Program aimed at a protected region sets program failure.
// - Locked protection mode: changing config one bits 6:2 sets program failure.
// - Password update after password mode was selected sets program failure.
// - Array erase that leaves a bit at zero sets erase failure.
// - Erase aimed at a protected region sets erase failure.
// - Register write whose erase phase leaves a zero sets erase failure.
// - Status-two bit 4 is one exactly while the integrity check is suspended.
// - End below start plus 3 sets abort bit 3, back to standby.
// - A valid check with end at least start plus 3 clears abort.
// - Failure flags hold busy and refuse new work until a clear command outside the last busy cycle.
package fes_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] FES_OFF_STATUS1  = 8'h00;
	localparam logic [7:0] FES_OFF_STATUS2  = 8'h04;
	localparam logic [7:0] FES_OFF_CONTROL  = 8'h08;
	localparam logic [7:0] FES_OFF_COMMAND  = 8'h0c;
	localparam logic [7:0] FES_OFF_START    = 8'h10;
	localparam logic [7:0] FES_OFF_END      = 8'h14;
	localparam logic [7:0] FES_OFF_CONFIG   = 8'h18;
	localparam logic [7:0] FES_OFF_IRQ_STAT = 8'h1c;
	localparam logic [7:0] FES_OFF_IRQ_MASK = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FES_ST1_BUSY      = 0;
	localparam int FES_ST1_PRG_FAIL  = 5;
	localparam int FES_ST1_ERS_FAIL  = 6;
	localparam int FES_ST2_ABORT     = 3;
	localparam int FES_ST2_SUSPEND   = 4;
	localparam int FES_CTL_PROT_LOCK0 = 1;
	localparam int FES_CTL_PROT_LOCK1 = 2;
	localparam int FES_CTL_PWD_MODE  = 3;
	localparam int FES_CTL_SUSPEND   = 4;
	localparam int FES_CFG_LOCK_LO   = 2;
	localparam int FES_CFG_LOCK_HI   = 6;
	localparam int FES_IRQ_PRG       = 0;
	localparam int FES_IRQ_ERS       = 1;
	localparam int FES_IRQ_ABORT     = 2;
	localparam int FES_IRQ_DONE      = 3;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0]  FES_CTL_RESET    = 8'h06;
	localparam logic [7:0]  FES_CFG_RESET    = 8'h00;
	localparam logic [3:0]  FES_MASK_RESET   = 4'h0;
	localparam logic [31:0] FES_CHECK_MARGIN = 32'h0000_0003;
	localparam int          FES_OP_TIME_NS   = 400;
	localparam int          FES_CLK_NS       = 40;
	localparam logic [3:0]  FES_OP_CYCLES    = 4'(FES_OP_TIME_NS / FES_CLK_NS);

	// ------------------------------------------------------------
	// Commands
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		FES_CMD_PROGRAM   = 4'h1,
		FES_CMD_ERASE     = 4'h2,
		FES_CMD_REG_WRITE = 4'h3,
		FES_CMD_PWD_WRITE = 4'h4,
		FES_CMD_CHECK     = 4'h5,
		FES_CMD_CLEAR     = 4'h6
	} fes_cmd_t;

	// Command word: opcode in [3:0], fault inputs from the array model in [15:13].
	typedef struct packed {
		logic        prot_hit;
		logic        erase_stuck;
		logic        prog_stuck;
		logic        unused;
		logic [7:0]  pad;
		logic [3:0]  opcode;
	} fes_cmd_word_t;

	typedef struct packed {
		logic        sel;
		logic        write;
		logic [7:0]  addr;
	} fes_bus_req_t;

endpackage

// [fes_reg_word.sv]
// Small 32-bit register with registered read-back, used for the check addresses.
// Assumes the caller supplies a one-cycle write strobe.
`timescale 1ns/1ps
module fes_reg_word
	import fes_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        we,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rdata <= 32'h0000_0000;
		else if (we)
			rdata <= wdata;
	end

endmodule

// [fes_top.sv]
// Failure-flag logic and second status register of a serial flash, on AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, zero wait states.
`timescale 1ns/1ps
module fes_top
	import fes_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FES_IDLE = 3'b001,
		FES_BUSY = 3'b010,
		FES_HOLD = 3'b100
	} fes_state_t;

	typedef struct packed {
		fes_state_t    fsm;
		fes_bus_req_t  req;
		logic [3:0]    op_cnt;
		logic          prg_fail;
		logic          ers_fail;
		logic          abort;
		logic [7:0]    control;
		logic [7:0]    config1;
		logic [3:0]    irq_stat;
		logic [3:0]    irq_mask;
		logic [31:0]   rdata;
		logic          irq;
	} fes_reg_t;

	fes_reg_t      r;
	fes_reg_t      next_r;
	logic [31:0]   start_addr;
	logic [31:0]   end_addr;
	logic          wr_start;
	logic          wr_end;
	logic [31:0]   status1;
	logic [31:0]   status2;
	fes_cmd_word_t cmd;
	logic [3:0]    ev;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input fes_bus_req_t q, input logic [7:0] off);
		hit = q.sel && q.write && (q.addr == off);
	endfunction

	// Abort test; a wide sum keeps an end near the top of the space honest.
	function automatic logic range_bad(input logic [31:0] s, input logic [31:0] e);
		range_bad = {1'b0, e} < ({1'b0, s} + {1'b0, FES_CHECK_MARGIN});
	endfunction

	assign cmd      = fes_cmd_word_t'(hwdata[15:0]);
	assign wr_start = hit(r.req, FES_OFF_START);
	assign wr_end   = hit(r.req, FES_OFF_END);

	fes_reg_word u_start (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (wr_start),
		.wdata   (hwdata),
		.rdata   (start_addr)
	);

	fes_reg_word u_end (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (wr_end),
		.wdata   (hwdata),
		.rdata   (end_addr)
	);

	// ------------------------------------------------------------
	// Status views
	// ------------------------------------------------------------
	always_comb
	begin
		status1 = 32'h0000_0000;
		status1[FES_ST1_BUSY]     = (r.fsm != FES_IDLE);
		status1[FES_ST1_PRG_FAIL] = r.prg_fail;
		status1[FES_ST1_ERS_FAIL] = r.ers_fail;
		// Reserved bits 7:5 stay zero; host writes are not stored.
		status2 = 32'h0000_0000;
		status2[FES_ST2_SUSPEND]  = r.control[FES_CTL_SUSPEND];
		status2[FES_ST2_ABORT]    = r.abort;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		ev     = 4'h0;
		next_r.req.sel   = hsel && hready && htrans[1];
		next_r.req.write = hwrite;
		next_r.req.addr  = haddr[7:0];

		// Operation timing.
		unique case (r.fsm)
			FES_IDLE:
			begin
				next_r.op_cnt = 4'h0;
			end
			FES_BUSY:
			begin
				if (r.op_cnt == FES_OP_CYCLES - 4'h1)
				begin
					next_r.fsm = (r.prg_fail || r.ers_fail) ? FES_HOLD : FES_IDLE;
					ev[FES_IRQ_DONE] = 1'b1;
				end
				else
					next_r.op_cnt = r.op_cnt + 4'h1;
			end
			FES_HOLD:
			begin
				next_r.op_cnt = 4'h0;
			end
		endcase

		// Commands; while busy only the clear command is accepted.
		if (hit(r.req, FES_OFF_COMMAND))
		begin
			if (cmd.opcode == FES_CMD_CLEAR)
			begin
				next_r.prg_fail = 1'b0;
				next_r.ers_fail = 1'b0;
				if (r.fsm == FES_HOLD)
					next_r.fsm = FES_IDLE;
			end
			else if (r.fsm == FES_IDLE)
			begin
				next_r.fsm    = FES_BUSY;
				next_r.op_cnt = 4'h0;
				unique case (cmd.opcode)
					FES_CMD_PROGRAM:
						if (cmd.prog_stuck || cmd.prot_hit)
							next_r.prg_fail = 1'b1;
					FES_CMD_ERASE:
						if (cmd.erase_stuck || cmd.prot_hit)
							next_r.ers_fail = 1'b1;
					FES_CMD_REG_WRITE:
					begin
						if ((!r.control[FES_CTL_PROT_LOCK0] || !r.control[FES_CTL_PROT_LOCK1])
							&& (hwdata[FES_CFG_LOCK_HI+16:FES_CFG_LOCK_LO+16]
							!= r.config1[FES_CFG_LOCK_HI:FES_CFG_LOCK_LO]))
							next_r.prg_fail = 1'b1;
						else
							next_r.config1 = hwdata[23:16];
						if (cmd.erase_stuck)
							next_r.ers_fail = 1'b1;
					end
					FES_CMD_PWD_WRITE:
						if (r.control[FES_CTL_PWD_MODE])
							next_r.prg_fail = 1'b1;
					FES_CMD_CHECK:
					begin
						if (range_bad(start_addr, end_addr))
						begin
							next_r.abort = 1'b1;
							next_r.fsm   = FES_IDLE;
							ev[FES_IRQ_ABORT] = 1'b1;
						end
						else
							next_r.abort = 1'b0;
					end
					default:
						next_r.fsm = FES_IDLE;
				endcase
			end
		end

		if (next_r.prg_fail && !r.prg_fail)
			ev[FES_IRQ_PRG] = 1'b1;
		if (next_r.ers_fail && !r.ers_fail)
			ev[FES_IRQ_ERS] = 1'b1;

		if (hit(r.req, FES_OFF_CONTROL))
			next_r.control = hwdata[7:0];
		if (hit(r.req, FES_OFF_IRQ_MASK))
			next_r.irq_mask = hwdata[3:0];
		// A new event wins over a write-one clear in the same cycle.
		if (hit(r.req, FES_OFF_IRQ_STAT))
			next_r.irq_stat = r.irq_stat & ~hwdata[3:0];
		next_r.irq_stat = next_r.irq_stat | ev;
		next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);

		// Read data registered at the address phase, ready for the data phase.
		next_r.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite)
		begin
			unique case (haddr[7:0])
				FES_OFF_STATUS1:  next_r.rdata = status1;
				FES_OFF_STATUS2:  next_r.rdata = status2;
				FES_OFF_CONTROL:  next_r.rdata = {24'h0, r.control};
				FES_OFF_START:    next_r.rdata = start_addr;
				FES_OFF_END:      next_r.rdata = end_addr;
				FES_OFF_CONFIG:   next_r.rdata = {24'h0, r.config1};
				FES_OFF_IRQ_STAT: next_r.rdata = {28'h0, r.irq_stat};
				FES_OFF_IRQ_MASK: next_r.rdata = {28'h0, r.irq_mask};
				default:          next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r          <= '0;
			r.fsm      <= FES_IDLE;
			r.control  <= FES_CTL_RESET;
			r.config1  <= FES_CFG_RESET;
			r.irq_mask <= FES_MASK_RESET;
		end
		else
			r <= next_r;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	assign hrdata = r.rdata;
	assign irq    = r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_fail_set;
		!$past(r.prg_fail) && r.prg_fail;
	endsequence

	property p_fail_sticky;
		@(posedge hclk) disable iff (!hresetn)
		r.prg_fail && !(hit(r.req, FES_OFF_COMMAND) && cmd.opcode == FES_CMD_CLEAR)
			|=> r.prg_fail;
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("program failure lost");

	property p_busy_fail;
		@(posedge hclk) disable iff (!hresetn)
		(r.prg_fail || r.ers_fail) |-> status1[FES_ST1_BUSY];
	endproperty
	a_busy_fail: assert property (p_busy_fail) else $error("busy low with failure");

	// Status two is checked where the host sees it, on the read data of its data phase.
	sequence s_st2_read;
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == FES_OFF_STATUS2;
	endsequence

	property p_suspend_bit;
		@(posedge hclk) disable iff (!hresetn)
		s_st2_read |=> hrdata[FES_ST2_SUSPEND] == $past(r.control[FES_CTL_SUSPEND]);
	endproperty
	a_suspend_bit: assert property (p_suspend_bit) else $error("suspend bit wrong");

	property p_reserved;
		@(posedge hclk) disable iff (!hresetn)
		s_st2_read |=> hrdata[7:5] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

	property p_abort;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_CHECK
			&& range_bad(start_addr, end_addr) |=> r.abort && r.fsm == FES_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not taken");

	property p_abort_clear;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_CHECK
			&& !range_bad(start_addr, end_addr) |=> !r.abort ##1 r.fsm == FES_BUSY;
	endproperty
	a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

	property p_prot_prog;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_PROGRAM
			&& (cmd.prog_stuck || cmd.prot_hit) |=> s_fail_set or r.prg_fail;
	endproperty
	a_prot_prog: assert property (p_prot_prog) else $error("program failure missed");

	property p_erase;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_ERASE
			&& (cmd.erase_stuck || cmd.prot_hit) |=> r.ers_fail ##[1:12] r.fsm == FES_HOLD;
	endproperty
	a_erase: assert property (p_erase) else $error("erase failure missed");

	property p_pwd;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_PWD_WRITE
			&& r.control[FES_CTL_PWD_MODE] |=> r.prg_fail;
	endproperty
	a_pwd: assert property (p_pwd) else $error("password failure missed");

	property p_cfg_lock;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_REG_WRITE
			&& !(r.control[FES_CTL_PROT_LOCK0] && r.control[FES_CTL_PROT_LOCK1])
			&& hwdata[FES_CFG_LOCK_HI+16:FES_CFG_LOCK_LO+16]
			!= r.config1[FES_CFG_LOCK_HI:FES_CFG_LOCK_LO]
			|=> r.prg_fail && r.config1 == $past(r.config1);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("locked config change taken");

	property p_reg_erase;
		@(posedge hclk) disable iff (!hresetn)
		hit(r.req, FES_OFF_COMMAND) && r.fsm == FES_IDLE && cmd.opcode == FES_CMD_REG_WRITE
			&& cmd.erase_stuck |=> r.ers_fail;
	endproperty
	a_reg_erase: assert property (p_reg_erase) else $error("register erase failure missed");

	property p_hold_refuse;
		@(posedge hclk) disable iff (!hresetn)
		r.fsm == FES_HOLD && !(hit(r.req, FES_OFF_COMMAND) && cmd.opcode == FES_CMD_CLEAR)
			|=> r.fsm == FES_HOLD;
	endproperty
	a_hold_refuse: assert property (p_hold_refuse) else $error("hold left without clear");

endmodule

// [fes_host_model.sv]
// Host controller model: an AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
module fes_host_model
	import fes_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	output logic             hang
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		hang = 1'b0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// A slave that never answers must not hang the run, so the wait is bounded.
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1)
			hang <= 1'b1;
	endtask

	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		if (wr && addr == FES_OFF_STATUS2)
			wd[7:5] = 3'b000;
		hsel <= 1'b1;
		haddr <= {24'h00_0000, addr};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		// Released data lines flip so that a stale value is never read as valid.
		hwdata <= ~wd;
	endtask
endmodule

// [fes_top_tb.sv]
// Self-checking testbench of the flash failure flags and status two block.
// Assumes a 25 MHz clock, zero wait states and the command word of the package.
`timescale 1ns/1ps
module fes_top_tb
	import fes_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        hang;
	logic [31:0] rd;
	int          miscompares = 0;
	int          compares = 0;
	logic [7:0]  f_ctl [7] = '{8'h06, 8'h06, 8'h04, 8'h0e, 8'h06, 8'h06, 8'h06};
	logic [31:0] f_cmd [7] = '{32'h2001, 32'h8001, 32'h3, 32'h4, 32'h4002, 32'h8002,
		32'h007c_4003};
	logic [31:0] f_st  [7] = '{32'h21, 32'h21, 32'h21, 32'h21, 32'h41, 32'h41, 32'h41};

	always #20 hclk = ~hclk;

	fes_top fes_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq(irq));
	fes_host_model fes_host_model_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hang(hang));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		fes_host_model_inst.xfer(1'b1, a, d, rd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] want);
		fes_host_model_inst.xfer(1'b0, a, 32'h0, rd);
		check(rd, want);
		check({31'h0, hresp}, 32'h0);
	endtask

	// The interrupt is registered, so it is looked at away from the edge.
	task automatic chk_irq(input logic want);
		@(negedge hclk);
		check({31'h0, irq}, {31'h0, want});
		@(posedge hclk);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		rd = 32'h1;
		while (rd[0] !== 1'b0 && n < 30)
		begin
			fes_host_model_inst.xfer(1'b0, FES_OFF_STATUS1, 32'h0, rd);
			n++;
		end
		if (rd[0] !== 1'b0)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask

	always @(posedge hang)
	begin
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rdc(FES_OFF_STATUS1, 32'h0);
		rdc(FES_OFF_STATUS2, 32'h0);
		rdc(FES_OFF_CONTROL, 32'h6);
		rdc(FES_OFF_CONFIG, 32'h0);
		rdc(FES_OFF_IRQ_MASK, 32'h0);
		wr(FES_OFF_STATUS2, 32'h18);
		rdc(FES_OFF_STATUS2, 32'h0);
		wr(8'h24, 32'hffff_ffff);
		rdc(8'h24, 32'h0);
		wr(FES_OFF_IRQ_MASK, 32'hf);
		wr(FES_OFF_COMMAND, 32'h007c_0003);
		rdc(FES_OFF_STATUS1, 32'h1);
		wait_idle();
		rdc(FES_OFF_CONFIG, 32'h7c);
		rdc(FES_OFF_IRQ_STAT, 32'h8);
		chk_irq(1'b1);
		wr(FES_OFF_IRQ_STAT, 32'h8);
		chk_irq(1'b0);
		for (int i = 0; i < 7; i++)
		begin
			wr(FES_OFF_CONTROL, {24'h0, f_ctl[i]});
			wr(FES_OFF_COMMAND, f_cmd[i]);
			repeat (12) @(posedge hclk);
			rdc(FES_OFF_STATUS1, f_st[i]);
			// A refused command would add the other failure flag if it ran.
			wr(FES_OFF_COMMAND, f_st[i][5] ? 32'h4002 : 32'h2001);
			rdc(FES_OFF_STATUS1, f_st[i]);
			chk_irq(1'b1);
			wr(FES_OFF_COMMAND, 32'h6);
			rdc(FES_OFF_STATUS1, 32'h0);
			wr(FES_OFF_IRQ_STAT, 32'hf);
			chk_irq(1'b0);
		end
		wr(FES_OFF_CONTROL, 32'h6);
		rdc(FES_OFF_CONFIG, 32'h7c);
		wr(FES_OFF_START, 32'h100);
		wr(FES_OFF_END, 32'h102);
		rdc(FES_OFF_START, 32'h100);
		wr(FES_OFF_COMMAND, 32'h5);
		rdc(FES_OFF_STATUS1, 32'h0);
		rdc(FES_OFF_STATUS2, 32'h8);
		chk_irq(1'b1);
		wr(FES_OFF_IRQ_MASK, 32'hb);
		chk_irq(1'b0);
		wr(FES_OFF_IRQ_MASK, 32'hf);
		chk_irq(1'b1);
		wr(FES_OFF_IRQ_STAT, 32'h4);
		chk_irq(1'b0);
		rdc(FES_OFF_STATUS2, 32'h8);
		wr(FES_OFF_END, 32'h103);
		wr(FES_OFF_COMMAND, 32'h5);
		wait_idle();
		rdc(FES_OFF_STATUS2, 32'h0);
		wr(FES_OFF_CONTROL, 32'h16);
		rdc(FES_OFF_STATUS2, 32'h10);
		wr(FES_OFF_CONTROL, 32'h6);
		rdc(FES_OFF_STATUS2, 32'h0);
		report_and_stop();
	end
endmodule
